// [rpag_defines.svh]
// offsets, field positions, reset values and sizes of the ram parity and access guard
`ifndef RPAG_DEFINES_SVH
`define RPAG_DEFINES_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RPAG_ACC_CTL_ADDR 20'hf0078
`define RPAG_PAR_CTL_ADDR 20'hf00f5
`define RPAG_IRQ_STAT_ADDR 20'hf0100
`define RPAG_IRQ_MASK_ADDR 20'hf0104
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RPAG_ACC_EN_BIT 7
`define RPAG_GSIZE_HI_BIT 5
`define RPAG_GSIZE_LO_BIT 4
`define RPAG_PORT_CFG_GUARD_BIT 2
`define RPAG_IRQ_REG_GUARD_BIT 1
`define RPAG_GCTRL_BIT 0
`define RPAG_PMASK_BIT 7
`define RPAG_PFLAG_BIT 0
`define RPAG_IRQ_PAR_BIT 0
`define RPAG_IRQ_BAD_BIT 1
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RPAG_ACC_CTL_RST 8'h00
`define RPAG_PAR_CTL_RST 8'h00
`define RPAG_IRQ_RST 2'h0
// ----------------------------------------------------------------------
// ram placement and guard sizes
// ----------------------------------------------------------------------
`define RPAG_RAM_BASE 20'hffb00
`define RPAG_RAM_AW 10
`define RPAG_RAM_BYTES 1024
`define RPAG_GUARD_128 11'h080
`define RPAG_GUARD_256 11'h100
`define RPAG_GUARD_512 11'h200
`endif

// [rpag_pkg.sv]
// types shared by the ram parity and access guard
package rpag_pkg;
    // ------------------------------------------------------------------
    // class of a special register, given by the sfr decoder
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPAG_SFR_OTHER = 2'b00, // unguarded register
        RPAG_SFR_PORT = 2'b01, // port configuration register
        RPAG_SFR_IRQ = 2'b10, // interrupt flag, mask, priority, edge
        RPAG_SFR_CTRL = 2'b11 // clock, oscillator, enable, voltage detect
    } rpag_sfr_cls_t;
    // ------------------------------------------------------------------
    // guard size codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPAG_G_NONE = 2'b00,
        RPAG_G_128 = 2'b01,
        RPAG_G_256 = 2'b10,
        RPAG_G_512 = 2'b11
    } rpag_gsize_t;
    // ------------------------------------------------------------------
    // one cpu access
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [19:0] addr; // byte address
        logic [7:0] wdata; // write byte
        logic wr; // write strobe
        logic rd; // read strobe
        logic fetch; // read is an instruction fetch
        rpag_sfr_cls_t cls; // class of an sfr address
        logic bad; // decoder saw an invalid access
    } rpag_req_t;
    // ------------------------------------------------------------------
    // forwarded sfr write
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr; // write pulse
        logic [19:0] addr; // target
        logic [7:0] wdata; // data
    } rpag_sfr_wr_t;
endpackage

// [rpag_guard.sv]
// ram parity generator and checker with ram, sfr and access guards
//
// Operation
// (RULE1) write to ram stores parity per byte
// (RULE2) data read checks stored byte parity
// (RULE3) instruction fetches skip parity check
// (RULE4) unmasked parity error resets, sets cause flag
// (RULE5) bit 7 masks parity resets when set
// (RULE6) bit 0 shows a parity error occurred
// (RULE7) guarded ram region reads, drops writes
// (RULE8) dropped guarded write raises nothing
// (RULE9) size field selects 0/128/256/512 low bytes
// (RULE10) control register bit layout, zeros in 6,3
// (RULE11) enable bit turns access detection on
// (RULE12) enable bit cannot be cleared until reset
// (RULE13) watchdog option enables detection automatically
// (RULE14) detected invalid access resets, sets cause
// (RULE15) port guard drops port configuration writes
// (RULE16) interrupt guard drops interrupt register writes
// (RULE17) control guard drops control register writes
// (RULE18) parity bit stored beside each byte
`timescale 1ns/1ps
`include "rpag_defines.svh"
module rpag_guard (
    input wire logic mclk,
    input wire logic rst_b,
    input rpag_pkg::rpag_req_t req,
    input wire logic [7:0] sfr_rdata,
    input wire logic wdt_opt_en,
    output logic [7:0] rdata,
    output rpag_pkg::rpag_sfr_wr_t sfr_wr,
    output logic int_rst_req,
    output logic bad_access_reset_cause,
    output logic irq
);
    import rpag_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // bytes covered by a guard size code
    function automatic logic [10:0] guard_limit(input logic [1:0] code);
        unique case (rpag_gsize_t'(code))
            RPAG_G_NONE: guard_limit = 11'h000;
            RPAG_G_128: guard_limit = `RPAG_GUARD_128;
            RPAG_G_256: guard_limit = `RPAG_GUARD_256;
            RPAG_G_512: guard_limit = `RPAG_GUARD_512;
        endcase
    endfunction

    // even parity of one byte
    function automatic logic par_of(input logic [7:0] b);
        par_of = ^b;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0] mem [0:`RPAG_RAM_BYTES-1]; // ram bytes
    logic par_mem [0:`RPAG_RAM_BYTES-1]; // parity beside each byte
    logic acc_en_ff; // access detection enable
    logic [1:0] gsize_ff; // ram guard size
    logic port_cfg_guard_ff; // port configuration guard
    logic irq_reg_guard_ff; // interrupt register guard
    logic gctrl_ff; // control register guard
    logic pmask_ff; // parity reset mask
    logic pflag_ff; // parity error flag
    logic [1:0] istat_ff; // sticky interrupt status
    logic [1:0] imask_ff; // interrupt mask
    logic [7:0] rdata_ff; // read data, one cycle after strobe
    logic chk_ff; // rdata_ff holds a checked ram byte
    logic par_q_ff; // stored parity of that byte
    rpag_sfr_wr_t sfr_wr_ff; // forwarded sfr write
    logic rst_req_ff; // internal reset pulse
    logic cause_ff; // reset cause, set by an invalid access or an unmasked parity error
    logic irq_ff; // interrupt level

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic in_ram; // address hits ram
    logic [`RPAG_RAM_AW-1:0] ram_off; // byte offset in ram
    logic in_guard; // address inside guarded region
    logic ram_wr_ok; // ram write allowed
    logic hit_acc, hit_par, hit_ist, hit_imk; // own registers
    logic own_hit; // any own register
    logic sfr_blocked; // sfr write dropped by its guard
    logic perr; // parity mismatch this cycle
    logic bad_evt; // enabled invalid access this cycle
    logic [10:0] off_full; // offset widened for compare
    logic [19:0] ram_rel; // address relative to ram base

    assign ram_rel = req.addr - `RPAG_RAM_BASE;
    // upper bound too, so addresses above ram never alias into it; the special registers sit below it
    assign in_ram = (req.addr >= `RPAG_RAM_BASE) && (ram_rel < 20'(`RPAG_RAM_BYTES));
    assign ram_off = ram_rel[`RPAG_RAM_AW-1:0];
    assign off_full = {1'b0, ram_off};
    assign in_guard = in_ram && (off_full < guard_limit(gsize_ff)); // RULE9
    assign ram_wr_ok = req.wr && in_ram && !in_guard; // RULE7
    assign hit_acc = (req.addr == `RPAG_ACC_CTL_ADDR);
    assign hit_par = (req.addr == `RPAG_PAR_CTL_ADDR);
    assign hit_ist = (req.addr == `RPAG_IRQ_STAT_ADDR);
    assign hit_imk = (req.addr == `RPAG_IRQ_MASK_ADDR);
    assign own_hit = hit_acc || hit_par || hit_ist || hit_imk;
    // guards keyed on the decoder's register class
    always_comb begin
        unique case (req.cls)
            RPAG_SFR_OTHER: sfr_blocked = 1'b0;
            RPAG_SFR_PORT: sfr_blocked = port_cfg_guard_ff; // RULE15
            RPAG_SFR_IRQ: sfr_blocked = irq_reg_guard_ff; // RULE16
            RPAG_SFR_CTRL: sfr_blocked = gctrl_ff; // RULE17
        endcase
    end
    assign perr = chk_ff && (par_of(rdata_ff) != par_q_ff); // RULE2
    assign bad_evt = req.bad && acc_en_ff; // RULE14

    // ------------------------------------------------------------------
    // ram and parity storage, written together
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (ram_wr_ok) begin
            mem[ram_off] <= req.wdata;
            par_mem[ram_off] <= par_of(req.wdata); // RULE1 RULE18
        end
    end

    // ------------------------------------------------------------------
    // read path, answer one cycle after strobe
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_ff <= 8'h00;
            chk_ff <= 1'b0;
            par_q_ff <= 1'b0;
        end else begin
            chk_ff <= req.rd && in_ram && !req.fetch; // RULE3
            par_q_ff <= 1'b0;
            if (!req.rd) begin
                // idle: keep zero on the read port
                rdata_ff <= 8'h00;
            end else if (in_ram) begin
                // ram byte, guarded or not
                rdata_ff <= mem[ram_off];
                par_q_ff <= par_mem[ram_off];
            end else if (hit_acc) begin
                // layout with zeros in bits 6 and 3
                rdata_ff <= {acc_en_ff, 1'b0, gsize_ff, 1'b0,
                             port_cfg_guard_ff, irq_reg_guard_ff, gctrl_ff}; // RULE10
            end else if (hit_par) begin
                rdata_ff <= {pmask_ff, 6'h00, pflag_ff}; // RULE6
            end else if (hit_ist) begin
                rdata_ff <= {6'h00, istat_ff};
            end else if (hit_imk) begin
                rdata_ff <= {6'h00, imask_ff};
            end else begin
                // any other sfr answers from outside
                rdata_ff <= sfr_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // access detection control register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_en_ff <= 1'(`RPAG_ACC_CTL_RST >> `RPAG_ACC_EN_BIT);
            gsize_ff <= 2'h0;
            port_cfg_guard_ff <= 1'b0;
            irq_reg_guard_ff <= 1'b0;
            gctrl_ff <= 1'b0;
        end else begin
            // set by software or the watchdog option, never cleared
            acc_en_ff <= acc_en_ff || wdt_opt_en
                || (req.wr && hit_acc && req.wdata[`RPAG_ACC_EN_BIT]); // RULE11 RULE12 RULE13
            if (req.wr && hit_acc) begin
                gsize_ff <= {req.wdata[`RPAG_GSIZE_HI_BIT],
                             req.wdata[`RPAG_GSIZE_LO_BIT]}; // RULE10
                port_cfg_guard_ff <= req.wdata[`RPAG_PORT_CFG_GUARD_BIT];
                irq_reg_guard_ff <= req.wdata[`RPAG_IRQ_REG_GUARD_BIT];
                gctrl_ff <= req.wdata[`RPAG_GCTRL_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // parity control register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pmask_ff <= 1'(`RPAG_PAR_CTL_RST >> `RPAG_PMASK_BIT);
            pflag_ff <= 1'b0;
        end else begin
            if (req.wr && hit_par && !gctrl_ff) begin
                // writes dropped while the control guard is on
                pmask_ff <= req.wdata[`RPAG_PMASK_BIT]; // RULE5 RULE17
            end
            if (perr) begin
                // error wins over a clearing write
                pflag_ff <= 1'b1; // RULE6
            end else if (req.wr && hit_par && !gctrl_ff && !req.wdata[`RPAG_PFLAG_BIT]) begin
                pflag_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // internal reset request and its cause
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_req_ff <= 1'b0;
            cause_ff <= 1'b0;
        end else begin
            rst_req_ff <= (perr && !pmask_ff) || bad_evt; // RULE4 RULE5 RULE14
            if ((perr && !pmask_ff) || bad_evt) begin
                cause_ff <= 1'b1; // RULE4 RULE14
            end
        end
    end

    // ------------------------------------------------------------------
    // forwarded sfr writes, dropped silently when guarded
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_wr_ff <= '0;
        end else begin
            sfr_wr_ff.wr <= req.wr && !in_ram && !own_hit && !sfr_blocked; // RULE15 RULE16 RULE17
            sfr_wr_ff.addr <= req.addr;
            sfr_wr_ff.wdata <= req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------------
    logic [1:0] evt; // this cycle's events
    logic [1:0] nxt_istat; // next status
    assign evt = {bad_evt, perr}; // guarded writes add nothing, RULE8
    assign nxt_istat = ((req.rd && hit_ist) ? 2'h0 : istat_ff) | evt;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            istat_ff <= `RPAG_IRQ_RST;
            imask_ff <= `RPAG_IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            istat_ff <= nxt_istat;
            if (req.wr && hit_imk) begin
                imask_ff <= req.wdata[1:0];
            end
            irq_ff <= |(nxt_istat & ((req.wr && hit_imk) ? req.wdata[1:0] : imask_ff));
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata = rdata_ff;
    assign sfr_wr = sfr_wr_ff;
    assign int_rst_req = rst_req_ff;
    assign bad_access_reset_cause = cause_ff;
    assign irq = irq_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    // a data read of ram, then its check one cycle later
    sequence s_data_read;
        req.rd && in_ram && !req.fetch;
    endsequence
    sequence s_checked;
        chk_ff;
    endsequence

    property p_write_parity;
        @(posedge mclk) disable iff (!rst_b)
        (ram_wr_ok && !req.rd) ##1 (req.rd && !req.wr && req.addr == $past(req.addr))
            |=> (par_q_ff == ^$past(req.wdata, 2));
    endproperty
    a_write_parity: assert property (p_write_parity) else $error("parity not stored"); // RULE1

    property p_check_read;
        @(posedge mclk) disable iff (!rst_b)
        s_data_read |=> s_checked;
    endproperty
    a_check_read: assert property (p_check_read) else $error("data read not checked"); // RULE2

    property p_fetch_skip;
        @(posedge mclk) disable iff (!rst_b)
        req.fetch |=> !chk_ff && !perr;
    endproperty
    a_fetch_skip: assert property (p_fetch_skip) else $error("fetch was checked"); // RULE3

    property p_perr_reset;
        @(posedge mclk) disable iff (!rst_b)
        (perr && !pmask_ff) |=> rst_req_ff ##1 cause_ff;
    endproperty
    a_perr_reset: assert property (p_perr_reset) else $error("no reset on parity"); // RULE4

    property p_mask_quiet;
        @(posedge mclk) disable iff (!rst_b)
        (perr && pmask_ff && !bad_evt) |=> !rst_req_ff && pflag_ff;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("masked parity reset"); // RULE5

    property p_guard_keeps;
        @(posedge mclk) disable iff (!rst_b)
        (req.wr && in_guard) |=> !rst_req_ff && !sfr_wr_ff.wr;
    endproperty
    a_guard_keeps: assert property (p_guard_keeps) else $error("guard write acted"); // RULE8

    property p_en_sticky;
        @(posedge mclk) disable iff (!rst_b)
        acc_en_ff |=> acc_en_ff [*3];
    endproperty
    a_en_sticky: assert property (p_en_sticky) else $error("enable cleared"); // RULE12

    property p_bad_reset;
        @(posedge mclk) disable iff (!rst_b)
        (req.bad && acc_en_ff) |=> rst_req_ff && cause_ff;
    endproperty
    a_bad_reset: assert property (p_bad_reset) else $error("no reset on bad access"); // RULE14

    property p_wdt_en;
        @(posedge mclk) disable iff (!rst_b)
        (wdt_opt_en && rst_b) |=> acc_en_ff;
    endproperty
    a_wdt_en: assert property (p_wdt_en) else $error("watchdog did not enable"); // RULE13

    property p_port_guard;
        @(posedge mclk) disable iff (!rst_b)
        (req.wr && req.cls == RPAG_SFR_PORT && port_cfg_guard_ff) |=> !sfr_wr_ff.wr;
    endproperty
    a_port_guard: assert property (p_port_guard) else $error("port write passed"); // RULE15

    // interrupt register writes never reach the far side while guarded
    property p_irq_guard;
        @(posedge mclk) disable iff (!rst_b)
        (req.wr && req.cls == RPAG_SFR_IRQ && irq_reg_guard_ff) |=> !sfr_wr_ff.wr;
    endproperty
    a_irq_guard: assert property (p_irq_guard) else $error("irq write passed"); // RULE16

    // read port rests at zero outside the answer cycle
    property p_read_idle;
        @(posedge mclk) disable iff (!rst_b)
        !req.rd |=> (rdata_ff == 8'h00);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read"); // RULE2

endmodule // rpag_guard

// [rpag_sfr_model.sv]
// far-side special register file that takes forwarded writes
`timescale 1ns/1ps
module rpag_sfr_model (
    input wire logic mclk,
    input wire logic rst_b,
    input rpag_pkg::rpag_sfr_wr_t sfr_wr,
    input wire logic rd,
    input wire logic [19:0] addr,
    output logic [7:0] sfr_rdata
);
    import rpag_pkg::*;
    logic [7:0] mem_ff [4]; // four byte registers, picked by low address bits
    logic [7:0] last_ff; // last byte put out on a read
    // ------------------------------------------------------------------
    // forwarded writes land one edge after the pulse
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mem_ff <= '{default: 8'h00};
        end else if (sfr_wr.wr) begin
            mem_ff[sfr_wr.addr[1:0]] <= sfr_wr.wdata;
        end
    end
    // remember the last read byte
    always_ff @(posedge mclk) begin
        if (rd) begin
            last_ff <= mem_ff[addr[1:0]];
        end
    end
    // outside a read the bus shows the inverse, so a stale byte never matches
    assign sfr_rdata = rd ? mem_ff[addr[1:0]] : ~last_ff;
endmodule // rpag_sfr_model

// [tb_top.sv]
// self-checking bench of the ram parity and access guard
`timescale 1ns/1ps
`include "rpag_defines.svh"
module tb_top;
    import rpag_pkg::*;
    // ------------------------------------------------------------------
    // table row: one access, write byte or expected read byte
    // ------------------------------------------------------------------
    typedef struct packed {
        logic w; // 1 write, 0 read
        logic [19:0] a; // address
        logic [7:0] d; // byte
        logic f; // fetch
    } rpag_row_t;
    localparam logic [19:0] RB = `RPAG_RAM_BASE;
    localparam logic [19:0] AC = `RPAG_ACC_CTL_ADDR;
    localparam logic [19:0] PC = `RPAG_PAR_CTL_ADDR;
    localparam logic [19:0] IS = `RPAG_IRQ_STAT_ADDR;
    localparam logic [19:0] IM = `RPAG_IRQ_MASK_ADDR;
    localparam rpag_sfr_cls_t OT = RPAG_SFR_OTHER;
    logic mclk;
    logic rst_b;
    rpag_req_t req;
    logic [7:0] sfr_rdata;
    logic wdt_opt_en;
    logic [7:0] rdata;
    rpag_sfr_wr_t sfr_wr;
    logic int_rst_req;
    logic bad_access_reset_cause;
    logic irq;
    int err_total = 0;
    int total_checks = 0;
    logic [19:0] lim; // guard size in bytes
    logic [19:0] lo; // last guarded byte
    rpag_row_t rows [12] = '{
        '{1, RB + 20'h300, 8'ha5, 0}, '{0, RB + 20'h300, 8'ha5, 0},
        '{1, RB + 20'h301, 8'h00, 0}, '{0, RB + 20'h301, 8'h00, 0},
        '{1, RB + 20'h3ff, 8'hff, 0}, '{0, RB + 20'h3ff, 8'hff, 1},
        '{1, 20'hf0200, 8'h3c, 0}, '{0, 20'hf0200, 8'h3c, 0},
        '{1, PC, 8'h81, 0}, '{0, PC, 8'h80, 0},
        '{1, AC, 8'h7f, 0}, '{0, AC, 8'h37, 0}};
    // ------------------------------------------------------------------
    // design, far side and clock
    // ------------------------------------------------------------------
    rpag_guard u_dut (.mclk(mclk), .rst_b(rst_b), .req(req), .sfr_rdata(sfr_rdata),
        .wdt_opt_en(wdt_opt_en), .rdata(rdata), .sfr_wr(sfr_wr), .int_rst_req(int_rst_req),
        .bad_access_reset_cause(bad_access_reset_cause), .irq(irq));
    rpag_sfr_model u_sfr (.mclk(mclk), .rst_b(rst_b), .sfr_wr(sfr_wr), .rd(req.rd),
        .addr(req.addr), .sfr_rdata(sfr_rdata));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus cycle, ends just after the edge that takes it
    task automatic acc(input logic w, input logic [19:0] a, input logic [7:0] d,
        input rpag_sfr_cls_t c, input logic f);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w, fetch: f, cls: c, bad: 1'b0};
        @(posedge mclk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input logic [19:0] a, input rpag_sfr_cls_t c, input logic [7:0] e);
        acc(0, a, 8'h00, c, 0);
        chk(rdata, e);
    endtask
    task automatic bad_pulse;
        @(posedge mclk);
        req.bad <= 1'b1;
        @(posedge mclk);
        req.bad <= 1'b0;
        #1;
    endtask
    task automatic do_reset;
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (6) @(posedge mclk);
        chk({5'h0, irq, int_rst_req, bad_access_reset_cause}, 8'h00);
        rst_b <= 1'b1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #50000;
        err_total++;
        wrap_up();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        req = '0;
        rst_b = 1'b0;
        wdt_opt_en = 1'b0;
        do_reset();
        rd(AC, OT, 8'h00);
        rd(PC, OT, 8'h00);
        $display("test reset done");
        // table of plain accesses
        foreach (rows[i]) begin
            if (rows[i].w) begin
                acc(1, rows[i].a, rows[i].d, OT, 0);
            end else begin
                acc(0, rows[i].a, 8'h00, OT, rows[i].f);
                chk(rdata, rows[i].d);
            end
        end
        $display("test table done");
        // write then read with no gap; the byte stands one cycle only
        @(posedge mclk);
        req <= '{addr: RB + 20'h302, wdata: 8'h6b, wr: 1'b1, rd: 1'b0, fetch: 1'b0,
            cls: OT, bad: 1'b0};
        @(posedge mclk);
        req <= '{addr: RB + 20'h302, wdata: 8'h00, wr: 1'b0, rd: 1'b1, fetch: 1'b0,
            cls: OT, bad: 1'b0};
        @(posedge mclk);
        req <= '0;
        #1;
        chk(rdata, 8'h6b);
        @(posedge mclk);
        #1;
        chk(rdata, 8'h00);
        $display("test back to back done");
        // each guard size: last guarded byte kept, first free byte written
        for (int g = 0; g < 4; g++) begin
            lim = (g == 0) ? 20'h0 : (20'h40 << g);
            lo = (g == 0) ? RB : RB + lim - 20'h1;
            acc(1, AC, 8'h00, OT, 0);
            acc(1, lo, 8'h11, OT, 0);
            acc(1, RB + lim, 8'h11, OT, 0);
            acc(1, AC, {2'b00, g[1:0], 4'h0}, OT, 0);
            acc(1, lo, 8'h33, OT, 0);
            acc(1, RB + lim, 8'h33, OT, 0);
            rd(lo, OT, (g == 0) ? 8'h33 : 8'h11);
            rd(RB + lim, OT, 8'h33);
            chk({6'h0, int_rst_req, irq}, 8'h00);
        end
        rd(IS, OT, 8'h00);
        $display("test ram guard done");
        // each sfr class dropped under its own guard bit
        for (int c = 1; c < 4; c++) begin
            acc(1, AC, 8'h00, OT, 0);
            acc(1, 20'hf0200 + 20'(c), 8'h5a, rpag_sfr_cls_t'(c[1:0]), 0);
            acc(1, AC, 8'h01 << (3 - c), OT, 0);
            acc(1, 20'hf0200 + 20'(c), 8'ha5, rpag_sfr_cls_t'(c[1:0]), 0);
            rd(20'hf0200 + 20'(c), rpag_sfr_cls_t'(c[1:0]), 8'h5a);
        end
        acc(1, PC, 8'h00, OT, 0);
        rd(PC, OT, 8'h80);
        acc(1, AC, 8'h00, OT, 0);
        $display("test sfr guard done");
        // invalid access: off, then on and sticky, interrupt unmasked and then masked
        acc(1, IM, 8'h03, OT, 0);
        bad_pulse();
        chk({6'h0, int_rst_req, bad_access_reset_cause}, 8'h00);
        acc(1, AC, 8'h80, OT, 0);
        acc(1, AC, 8'h00, OT, 0);
        rd(AC, OT, 8'h80);
        bad_pulse();
        chk({6'h0, int_rst_req, bad_access_reset_cause}, 8'h03);
        @(posedge mclk);
        #1;
        chk({7'h0, irq}, 8'h01);
        rd(IS, OT, 8'h02);
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h0, irq}, 8'h00);
        acc(1, IM, 8'h00, OT, 0);
        bad_pulse();
        repeat (2) @(posedge mclk);
        #1;
        chk({7'h0, irq}, 8'h00);
        rd(IS, OT, 8'h02);
        $display("test invalid access done");
        // watchdog option turns detection on by itself
        @(posedge mclk);
        wdt_opt_en <= 1'b1;
        do_reset();
        repeat (2) @(posedge mclk);
        rd(AC, OT, 8'h80);
        bad_pulse();
        chk({6'h0, int_rst_req, bad_access_reset_cause}, 8'h03);
        $display("test watchdog option done");
        wrap_up();
    end
endmodule // tb_top
